// ### logic/swd_pkg.sv
/*
 * Shared types and constants for the switch mode controller and its
 * serial command port.
 * Assumes a 125 MHz internal clock and an 8-bit serial command word.
 */
package swd_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int WD_BASE_US = 10000;
    localparam int WD_BASE_CYC = WD_BASE_US * CLK_MHZ;
    localparam int SPI_BITS = 8;

    // ------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SWD_SLEEP = 2'b00,
        SWD_NORMAL = 2'b01,
        SWD_FAULT = 2'b10,
        SWD_FAILSAFE = 2'b11
    } swd_mode_t;

    // ------------------------------------------------------------------
    // Decoded fail-safe resistor code
    // ------------------------------------------------------------------
    localparam logic [1:0] FSR_DISABLED = 2'h0;
    localparam logic [1:0] FSR_BOTH_OFF = 2'h1;
    localparam logic [1:0] FSR_CH0_ON = 2'h2;
    localparam logic [1:0] FSR_BOTH_ON = 2'h3;

    // ------------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------------
    localparam int CMD_WD_BIT = 7;
    localparam int CMD_ADDR_HI = 6;
    localparam int CMD_ADDR_LO = 4;
    localparam logic [2:0] ADDR_OUTPUT = 3'h0;
    localparam logic [2:0] ADDR_WATCHDOG = 3'h1;
    localparam logic [2:0] ADDR_OVERVOLT = 3'h2;
    localparam logic [2:0] ADDR_OCLEVEL = 3'h3;
    localparam logic [2:0] ADDR_OCTIME = 3'h4;

    // ------------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------------
    localparam int ST_OTF = 7;
    localparam int ST_OCF = 6;
    localparam int ST_OLF = 5;
    localparam int ST_UVF = 4;
    localparam int ST_FAULT = 3;
    localparam int ST_WATCHDOG_EXPIRED_FLAG = 2;
    localparam int ST_OVF = 1;
    localparam int ST_FSI = 0;

    // ------------------------------------------------------------------
    // Configuration and sense carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] oc_low;
        logic oc_high;
        logic [1:0] oc_time;
    } swd_oc_sel_t;

    typedef struct packed {
        logic overvoltage_disable;
        logic wd_en;
        logic [1:0] wd_period;
        swd_oc_sel_t oc;
        logic [1:0] spi_on;
    } swd_cfg_t;

    typedef struct packed {
        logic [1:0] ot_hot;
        logic [1:0] open_load;
        logic [1:0] overcur;
        logic overvolt;
        logic undervolt;
    } swd_sense_t;

    localparam swd_oc_sel_t OC_DEFAULT = 6'h00;
    localparam swd_cfg_t CFG_RESET = 12'h000;

endpackage

// ### logic/swd_spi_port.sv
/*
 * Serial command port: samples chip select, shift clock and data with
 * the system clock, shifts a command in and a status word out.
 * Assumes the shift clock is slow enough to see each level for several
 * system clock cycles.
 */
`timescale 1ns/100ps

module swd_spi_port (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic spi_cs_n, // Chip select pin, active low
    input wire logic spi_sclk, // Shift clock pin
    input wire logic spi_si, // Serial data in pin
    input wire logic [7:0] tx_byte, // Status word to send
    output logic spi_so_o, // Serial data out level
    output logic spi_so_oe, // Serial data out enable
    output logic rx_valid, // Pulse: valid 8-bit command
    output logic [7:0] rx_byte // Last valid command
);
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic sclk_d_r;
    logic cs_d_r;
    logic [7:0] rx_sh_r;
    logic [7:0] tx_sh_r;
    logic [3:0] cnt_r;
    logic cs_s;
    logic sclk_s;
    logic si_s;
    logic sel;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    // ------------------------------------------------------------------
    // Pin sampling and edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 3'h1;
            sync2_r <= 3'h1;
        end else begin
            sync1_r <= {spi_si, spi_sclk, spi_cs_n};
            sync2_r <= sync1_r;
        end
    end

    assign cs_s = sync2_r[0];
    assign sclk_s = sync2_r[1];
    assign si_s = sync2_r[2];
    assign sel = ~cs_s;
    assign sclk_rise = sel & sclk_s & ~sclk_d_r;
    assign sclk_fall = sel & ~sclk_s & sclk_d_r;
    assign cs_fall = ~cs_s & cs_d_r;
    assign cs_rise = cs_s & ~cs_d_r;

    // Output drives only while selected
    assign spi_so_oe = sel;
    assign spi_so_o = tx_sh_r[7];

    // ------------------------------------------------------------------
    // Shift registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            rx_sh_r <= 8'h00;
            tx_sh_r <= 8'h00;
            cnt_r <= 4'h0;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            sclk_d_r <= sclk_s;
            cs_d_r <= cs_s;
            rx_valid <= cs_rise & (cnt_r == 4'(swd_pkg::SPI_BITS));
            if (cs_rise && cnt_r == 4'(swd_pkg::SPI_BITS)) begin
                rx_byte <= rx_sh_r;
            end
            if (cs_fall) begin
                tx_sh_r <= tx_byte;
                cnt_r <= 4'h0;
            end else begin
                // Sample on rising edge, MSB first
                if (sclk_rise) begin
                    rx_sh_r <= {rx_sh_r[6:0], si_s};
                    if (cnt_r != 4'hf) begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                if (sclk_fall) begin
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                end
            end
        end
    end

endmodule

// ### logic/swd_ctrl.sv
/*
 * Mode controller for a dual high-side switch: sleep, normal, fault and
 * fail-safe modes, watchdog, fault flag pin and sticky fault flags.
 * Assumes all pin and analog sense inputs are asynchronous, and that the
 * fail-safe resistor arrives already decoded to a two-bit code.
 */
// Notes on behaviour
// - Both wake pins low: sleep, outputs off
// - Power-up starts in sleep mode
// - Sleep makes serial settings read zero
// - Reset pin high, no fault: normal mode
// - Watchdog arms on wake or reset rise
// - Watchdog expiry latches fail-safe mode
// - Fail-safe outputs follow resistor code
// - Fail-safe entry restores overcurrent defaults
// - Protection stays active during fail-safe
// - Status bit two shows fail-safe
// - Leave fail-safe: both pins low, or grounded
// - Grounded select disables watchdog and fail-safe
// - Logic supply loss clears all settings
// - Without supply, direct inputs drive outputs
// - Faults pull flag low, faulted channel off
// - Flag releases unless overcurrent or undervoltage
// - Fault word shifted out, cleared by transfer
// - Overtemperature sensed only while channel on
// - Overtemperature retries after cooling
// - Overtemperature flag cleared by read
// - Overvoltage flag at status bit one
// - Overvoltage holds output off while present
// - Overvoltage disable suppresses shutdown and flag
// - Eight-bit commands, MSB first, rising sample
// - Serial output driven only while selected
// - Reset pin low clears settings and faults
`timescale 1ns/100ps

module swd_ctrl #(
    parameter int WD_BASE_CYC = swd_pkg::WD_BASE_CYC
) (
    input wire logic clk, // 125 MHz internal clock
    input wire logic rst, // Async reset, active high
    input wire logic wake_input, // Wake pin
    input wire logic sleep_reset_n, // Reset pin, active low
    input wire logic [1:0] failsafe_resistor, // Decoded resistor code
    input wire logic direct_input_0, // Direct control, channel 0
    input wire logic direct_input_1, // Direct control, channel 1
    input wire logic logic_supply_ok, // Logic supply in range
    input wire swd_pkg::swd_sense_t sense, // Analog fault sensing
    input wire logic spi_cs_n, // Chip select, active low
    input wire logic spi_sclk, // Serial shift clock
    input wire logic spi_si, // Serial data in
    output logic spi_so_o, // Serial data out level
    output logic spi_so_oe, // Serial data out enable
    output logic output_channel_0, // Switch drive, channel 0
    output logic output_channel_1, // Switch drive, channel 1
    output logic fault_flag_n_o, // Fault pin level
    output logic fault_flag_n_oe, // Fault pin pull-down enable
    output swd_pkg::swd_oc_sel_t oc_sel, // Overcurrent selections
    output swd_pkg::swd_mode_t mode, // Current mode
    output logic watchdog_expired_flag // High in fail-safe
);
    localparam int IN_W = 15;

    logic [IN_W-1:0] sync1_r, sync2_r;
    logic wake_d_r, rstn_d_r, wd_armed_r, wd_last_r, uv_hold_r, fault_r;
    swd_pkg::swd_mode_t mode_r, mode_nxt;
    swd_pkg::swd_cfg_t cfg_r, cfg_nxt, cfg_eff;
    logic [31:0] wd_cnt_r;
    logic [1:0] out_r, ot_hold_r, oc_lat_r;
    logic [4:0] flag_r;

    logic wake_s, rstn_s, vdd_s, wake_rise, rstn_rise, both_low, fs_enabled;
    logic awake, rx_valid, wd_toggle, wd_run, wd_expire, ov_block;
    logic uv_hold_nxt, fault_now, enter_fs;
    logic [1:0] fsr_s, din_s, cmd, fs_pat, want, ol_act, on_nxt;
    logic [1:0] ot_hold_nxt, oc_lat_nxt;
    swd_pkg::swd_sense_t sense_s;
    logic [7:0] rx_byte, status;
    logic [2:0] rx_addr;
    logic [31:0] wd_limit;
    logic [4:0] flag_set, flag_clr, flag_nxt;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_r <= 15'h0000;
            sync2_r <= 15'h0000;
        end else begin
            sync1_r <= {sense, logic_supply_ok, direct_input_1,
                        direct_input_0, failsafe_resistor,
                        sleep_reset_n, wake_input};
            sync2_r <= sync1_r;
        end
    end

    // Decoded synchronised inputs
    assign wake_s = sync2_r[0];
    assign rstn_s = sync2_r[1];
    assign fsr_s = sync2_r[3:2];
    assign din_s = sync2_r[5:4];
    assign vdd_s = sync2_r[6];
    assign sense_s = sync2_r[14:7];
    assign wake_rise = wake_s & ~wake_d_r;
    assign rstn_rise = rstn_s & ~rstn_d_r;
    assign both_low = ~wake_s & ~rstn_s;
    assign fs_enabled = fsr_s != swd_pkg::FSR_DISABLED;
    assign awake = mode_r != swd_pkg::SWD_SLEEP;

    // ------------------------------------------------------------------
    // Serial command port
    // ------------------------------------------------------------------
    swd_spi_port u_port (
        .clk(clk),
        .rst(rst),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_si(spi_si),
        .tx_byte(status),
        .spi_so_o(spi_so_o),
        .spi_so_oe(spi_so_oe),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte)
    );

    // Status word shifted out on each transfer
    always_comb begin
        status = 8'h00;
        status[swd_pkg::ST_OTF] = flag_r[4];
        status[swd_pkg::ST_OCF] = flag_r[3];
        status[swd_pkg::ST_OLF] = flag_r[2];
        status[swd_pkg::ST_UVF] = flag_r[1];
        status[swd_pkg::ST_OVF] = flag_r[0];
        status[swd_pkg::ST_FAULT] = fault_r;
        status[swd_pkg::ST_WATCHDOG_EXPIRED_FLAG] = watchdog_expired_flag;
        status[swd_pkg::ST_FSI] = fs_enabled;
    end

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    assign rx_addr = rx_byte[swd_pkg::CMD_ADDR_HI:swd_pkg::CMD_ADDR_LO];
    assign enter_fs = (mode_nxt == swd_pkg::SWD_FAILSAFE) &&
                      (mode_r != swd_pkg::SWD_FAILSAFE);

    // Settings read as zero while asleep
    assign cfg_eff = awake ? cfg_r : swd_pkg::CFG_RESET;

    // Register write decode and clearing
    always_comb begin
        cfg_nxt = cfg_r;
        if (rx_valid && awake) begin
            unique case (rx_addr)
                swd_pkg::ADDR_OUTPUT: cfg_nxt.spi_on = rx_byte[1:0];
                swd_pkg::ADDR_WATCHDOG: begin
                    cfg_nxt.wd_en = rx_byte[2];
                    cfg_nxt.wd_period = rx_byte[1:0];
                end
                swd_pkg::ADDR_OVERVOLT: cfg_nxt.overvoltage_disable = rx_byte[0];
                swd_pkg::ADDR_OCLEVEL: begin
                    cfg_nxt.oc.oc_high = rx_byte[3];
                    cfg_nxt.oc.oc_low = rx_byte[2:0];
                end
                swd_pkg::ADDR_OCTIME: cfg_nxt.oc.oc_time = rx_byte[1:0];
                default: cfg_nxt = cfg_r;
            endcase
        end
        if (enter_fs) begin
            cfg_nxt.oc = swd_pkg::OC_DEFAULT;
        end
        if (!vdd_s || !rstn_s) begin
            cfg_nxt = swd_pkg::CFG_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    // Toggle of command bit seven restarts the count
    assign wd_toggle = rx_valid &
                       (rx_byte[swd_pkg::CMD_WD_BIT] != wd_last_r);
    // Runs only if enabled and armed; also during fail-safe
    assign wd_run = wd_armed_r & cfg_eff.wd_en & fs_enabled;
    assign wd_limit = 32'(WD_BASE_CYC) << cfg_eff.wd_period;
    assign wd_expire = wd_run && (wd_cnt_r >= wd_limit - 32'h1);

    // Arming, count and last seen toggle bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_armed_r <= 1'b0;
            wd_last_r <= 1'b0;
            wd_cnt_r <= 32'h0;
        end else begin
            if (!fs_enabled || both_low) begin
                wd_armed_r <= 1'b0;
            end else if (wake_rise || rstn_rise) begin
                wd_armed_r <= 1'b1;
            end
            if (rx_valid) begin
                wd_last_r <= rx_byte[swd_pkg::CMD_WD_BIT];
            end
            if (!wd_run || wd_toggle || wake_rise || rstn_rise) begin
                wd_cnt_r <= 32'h0;
            end else if (!wd_expire) begin
                wd_cnt_r <= wd_cnt_r + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    always_comb begin
        mode_nxt = swd_pkg::SWD_NORMAL;
        if (both_low) begin
            mode_nxt = swd_pkg::SWD_SLEEP;
        end else if (mode_r == swd_pkg::SWD_FAILSAFE && fs_enabled) begin
            mode_nxt = swd_pkg::SWD_FAILSAFE;
        end else if (wd_expire) begin
            mode_nxt = swd_pkg::SWD_FAILSAFE;
        end else if (fault_now) begin
            mode_nxt = swd_pkg::SWD_FAULT;
        end else begin
            mode_nxt = swd_pkg::SWD_NORMAL;
        end
    end

    // ------------------------------------------------------------------
    // Output control and protection
    // ------------------------------------------------------------------
    // Serial control or direct inputs; direct acts with or without supply
    assign cmd = cfg_eff.spi_on | din_s;

    // Fail-safe pattern from resistor code
    assign fs_pat = (fsr_s == swd_pkg::FSR_BOTH_ON) ? 2'h3 :
                    (fsr_s == swd_pkg::FSR_CH0_ON) ? 2'h1 : 2'h0;

    // Requested drive per mode
    assign want = (mode_r == swd_pkg::SWD_FAILSAFE) ? fs_pat :
                  awake ? cmd : 2'h0;

    // Overvoltage shutdown unless disabled
    assign ov_block = sense_s.overvolt & ~cfg_eff.overvoltage_disable;

    // Sensing only while on; retry after cooling
    assign ot_hold_nxt = (out_r & sense_s.ot_hot) |
                         (ot_hold_r & sense_s.ot_hot & want);
    // Overcurrent latches until commanded off
    assign oc_lat_nxt = (out_r & sense_s.overcur) | (oc_lat_r & want);
    // Undervoltage holds while a channel stays commanded on
    assign uv_hold_nxt = sense_s.undervolt | (uv_hold_r & (|want));
    assign ol_act = sense_s.open_load & ~out_r & {2{awake}};

    // Faulted channel forced off
    assign on_nxt = want & ~ot_hold_r & ~oc_lat_r &
                    ~{2{ov_block}} & ~{2{uv_hold_r}};

    // Any present fault pulls the flag pin while awake
    assign fault_now = awake & ((|ot_hold_r) | (|ol_act) | (|oc_lat_r) |
                                ov_block | uv_hold_r);

    // Drive and protection state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_r <= swd_pkg::SWD_SLEEP;
            cfg_r <= swd_pkg::CFG_RESET;
            wake_d_r <= 1'b0;
            rstn_d_r <= 1'b0;
            out_r <= 2'h0;
            ot_hold_r <= 2'h0;
            oc_lat_r <= 2'h0;
            uv_hold_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            cfg_r <= cfg_nxt;
            wake_d_r <= wake_s;
            rstn_d_r <= rstn_s;
            out_r <= on_nxt;
            ot_hold_r <= ot_hold_nxt;
            oc_lat_r <= oc_lat_nxt;
            uv_hold_r <= uv_hold_nxt;
            fault_r <= fault_now;
        end
    end

    // ------------------------------------------------------------------
    // Sticky fault flags: otf, ocf, olf, uvf, ovf
    // ------------------------------------------------------------------
    assign flag_set = {|(out_r & sense_s.ot_hot),
                       |(out_r & sense_s.overcur),
                       |ol_act,
                       awake & sense_s.undervolt,
                       awake & ov_block};
    // Cleared by a valid transfer or reset pin low
    assign flag_clr = {5{rx_valid | ~rstn_s}};
    // New event wins over a clear in the same cycle
    assign flag_nxt = flag_set | (flag_r & ~flag_clr);

    // Flag storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_r <= 5'h00;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign output_channel_0 = out_r[0];
    assign output_channel_1 = out_r[1];
    assign fault_flag_n_o = ~fault_r;
    assign fault_flag_n_oe = fault_r;
    assign mode = mode_r;
    assign watchdog_expired_flag = mode_r == swd_pkg::SWD_FAILSAFE;

    // Overcurrent selections; defaults whenever settings are cleared
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oc_sel <= swd_pkg::OC_DEFAULT;
        end else begin
            oc_sel <= cfg_eff.oc;
        end
    end

endmodule

// ### verif/swd_ctrl_sva.sv
/* Port checker for swd_ctrl.
   Assumes one clock domain and the async reset rst. */
`timescale 1ns/100ps
module swd_ctrl_sva (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic wake_input, // Wake pin
    input wire logic sleep_reset_n, // Reset pin
    input wire logic [1:0] failsafe_resistor, // Resistor code
    input wire logic logic_supply_ok, // Supply good
    input wire swd_pkg::swd_sense_t sense, // Sensing
    input wire logic spi_cs_n, // Chip select
    input wire logic spi_so_oe, // SO enable
    input wire logic output_channel_0, // Channel 0
    input wire logic output_channel_1, // Channel 1
    input wire logic fault_flag_n_oe, // Fault pull-down
    input wire swd_pkg::swd_oc_sel_t oc_sel, // Overcurrent sel
    input wire swd_pkg::swd_mode_t mode, // Mode
    input wire logic watchdog_expired_flag // Expiry flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic fs;
    logic [1:0] pat;
    // Mode decode and expected fail-safe pattern
    assign fs = (mode == swd_pkg::SWD_FAILSAFE);
    assign pat = (failsafe_resistor == swd_pkg::FSR_BOTH_ON) ? 2'h3 :
        (failsafe_resistor == swd_pkg::FSR_CH0_ON) ? 2'h1 : 2'h0;
    chk_pins_sleep: assert property (
        (!wake_input && !sleep_reset_n)[*5]
        |-> mode == swd_pkg::SWD_SLEEP) else $error("not asleep");
    chk_sleep_off: assert property (
        (mode == swd_pkg::SWD_SLEEP)[*3]
        |-> !output_channel_0 && !output_channel_1) else $error("on in sleep");
    chk_so_idle: assert property (spi_cs_n[*4] |-> !spi_so_oe)
        else $error("SO driven");
    chk_fsi_ground: assert property (
        (failsafe_resistor == 2'h0)[*5]
        |-> !fs) else $error("fail-safe while grounded");
    chk_fs_latch: assert property (
        (fs && failsafe_resistor != 2'h0 && (wake_input || sleep_reset_n))[*3]
        |=> fs && watchdog_expired_flag) else $error("fail-safe lost");
    chk_fs_pattern: assert property ((fs && sense == '0
        && failsafe_resistor != 2'h0)[*3]
        |-> {output_channel_1, output_channel_0} == pat)
        else $error("bad fail-safe pattern");
    chk_oc_default: assert property ($rose(fs) |-> ##[0:2]
        oc_sel == swd_pkg::OC_DEFAULT) else $error("oc not default");
    chk_supply_clr: assert property ((!logic_supply_ok)[*5]
        |-> oc_sel == swd_pkg::OC_DEFAULT) else $error("oc kept");
    chk_ov_off: assert property ((sense.overvolt
        && mode != swd_pkg::SWD_SLEEP)[*6] |-> fault_flag_n_oe
        && !output_channel_0 && !output_channel_1) else $error("ov on");
    cov_fs: cover property (fs);
    cov_fault: cover property (fault_flag_n_oe);
    cov_xfer: cover property ($fell(spi_so_oe));
endmodule
bind swd_ctrl swd_ctrl_sva i_swd_ctrl_sva (.*);

// ### verif/swd_host_model.sv
/* Host side of the serial link: sends a command MSB first and captures
   the status word. Assumes the 8 ns system clock. */
`timescale 1ns/100ps
module swd_host_model (
    input wire logic clk, // System clock
    input wire logic spi_so_o, // Status bit in
    output logic spi_cs_n, // Chip select
    output logic spi_sclk, // Shift clock
    output logic spi_si, // Command bit out
    output logic [7:0] status // Last status word
);
    // Idle link
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_si = 1'b0;
        status = 8'h00;
    end
    // Wait n edges then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One transfer, 64 ns shift clock
    task automatic xfer(input logic [7:0] cmd);
        tick(1);
        spi_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            spi_si = cmd[i];
            tick(i == 7 ? 8 : 4);
            spi_sclk = 1'b1;
            status[i] = spi_so_o;
            tick(4);
            spi_sclk = 1'b0;
        end
        spi_si = ~spi_si; // Stale level never held
        tick(4);
        spi_cs_n = 1'b1;
        tick(8);
    endtask
endmodule

// ### verif/swd_ctrl_tb.sv
/* Self-checking bench for swd_ctrl.
   Assumes swd_host_model drives the serial pins. */
`timescale 1ns/100ps
module swd_ctrl_tb;
    logic clk, rst, wake_input, sleep_reset_n, direct_input_0;
    logic direct_input_1, logic_supply_ok, spi_cs_n, spi_sclk, spi_si;
    logic spi_so_o, spi_so_oe, output_channel_0, output_channel_1;
    logic fault_flag_n_o, fault_flag_n_oe, watchdog_expired_flag, wd;
    logic [1:0] failsafe_resistor;
    logic [3:0] d;
    logic [7:0] status;
    swd_pkg::swd_sense_t sense;
    swd_pkg::swd_oc_sel_t oc_sel;
    swd_pkg::swd_mode_t mode;
    int num_errors = 0;
    int checks_done = 0;
    swd_ctrl #(.WD_BASE_CYC(256)) i_swd_ctrl (.*);
    swd_host_model i_swd_host_model (.*);
    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic tick(input int n);
        i_swd_host_model.tick(n);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Command with the watchdog bit inverted
    task automatic cmd(input logic [2:0] a, input logic [3:0] v);
        wd = ~wd;
        i_swd_host_model.xfer({wd, a, v});
    endtask
    function automatic logic [1:0] fs_out(input logic [1:0] r);
        return r == 2'h3 ? 2'h3 : r == 2'h2 ? 2'h1 : 2'h0;
    endfunction
    task automatic wrap_up;
        if (num_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        tick(30000);
        num_errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {rst, wd, wake_input, sleep_reset_n, direct_input_0} = 5'h10;
        {direct_input_1, failsafe_resistor, logic_supply_ok} = 4'h1;
        sense = '0;
        void'($urandom(32'h8841));
        tick(16);
        rst = 1'b0;
        tick(2);
        check(mode, swd_pkg::SWD_SLEEP);
        check(spi_so_oe, 8'h00);
        for (int r = 0; r < 4; r++) begin
            failsafe_resistor = 2'(r);
            {wake_input, sleep_reset_n} = 2'h3;
            tick(6);
            check(mode, swd_pkg::SWD_NORMAL);
            check(fault_flag_n_o, 8'h01);
            d = 4'($urandom_range(15, 1));
            cmd(3'h3, d);
            check(oc_sel, {d[2:0], d[3], 2'h0});
            cmd(3'h1, 4'h4);
            repeat (3) begin
                {direct_input_1, direct_input_0} = 2'($urandom);
                cmd(3'h5, 4'h0);
                check(mode, swd_pkg::SWD_NORMAL);
                check({output_channel_1, output_channel_0},
                    {direct_input_1, direct_input_0});
            end
            tick(300);
            check(mode, r ? swd_pkg::SWD_FAILSAFE
                : swd_pkg::SWD_NORMAL);
            check(watchdog_expired_flag, r != 0);
            check({output_channel_1, output_channel_0},
                r ? fs_out(2'(r)) : {direct_input_1, direct_input_0});
            check(oc_sel, r ? 6'h00 : {d[2:0], d[3], 2'h0});
            cmd(3'h5, 4'h0);
            check(status[2], r != 0);
            {wake_input, sleep_reset_n} = 2'h0;
            tick(6);
            check(mode, swd_pkg::SWD_SLEEP);
            check({output_channel_1, output_channel_0}, 8'h00);
        end
        {wake_input, sleep_reset_n, direct_input_1, direct_input_0} = 4'hf;
        tick(6);
        cmd(3'h3, 4'h9);
        logic_supply_ok = 1'b0;
        tick(6);
        check(oc_sel, 8'h00);
        check({output_channel_1, output_channel_0}, 8'h03);
        logic_supply_ok = 1'b1;
        sense.ot_hot = 2'h1;
        tick(8);
        check({output_channel_1, output_channel_0}, 8'h02);
        sense.ot_hot = 2'h0;
        tick(8);
        check({output_channel_1, output_channel_0}, 8'h03);
        sense.overvolt = 1'b1;
        tick(8);
        check({fault_flag_n_oe, output_channel_1,
            output_channel_0}, 8'h04);
        sense.overvolt = 1'b0;
        tick(8);
        check({fault_flag_n_oe, output_channel_1,
            output_channel_0}, 8'h03);
        cmd(3'h5, 4'h0);
        check({status[7], status[1]}, 8'h03);
        cmd(3'h5, 4'h0);
        check({status[7], status[1]}, 8'h00);
        wrap_up();
    end
endmodule
